//--- rtl/cdma_consts.svh
// Register offsets, field positions and reset values of the chunked DMA engine.
`ifndef CDMA_CONSTS_SVH
`define CDMA_CONSTS_SVH
`define CDMA_OFF_DEST_PTR 8'h00
`define CDMA_OFF_DEST_BASE 8'h04
`define CDMA_OFF_SRC_PTR 8'h08
`define CDMA_OFF_SRC_BASE 8'h0C
`define CDMA_OFF_STRIDES 8'h10
`define CDMA_OFF_STATUS 8'h14
`define CDMA_OFF_CONTROL 8'h18
`define CDMA_OFF_BYTES 8'h1C
`define CDMA_OFF_CHUNK_SIZE 8'h20
`define CDMA_BIT_DONE 0
`define CDMA_BIT_BUSY 1
`define CDMA_BIT_RUNNING 4
`define CDMA_BIT_ERROR 6
`define CDMA_BIT_REQUEST 0
`define CDMA_BIT_SUSPEND 1
`define CDMA_RST_WORD 32'h0000_0000
`endif

//--- rtl/cdma_pkg.sv
// Types shared by the chunked DMA engine.
package cdma_pkg;
   typedef enum logic [1:0] {
      CDMA_IDLE,
      CDMA_READ,
      CDMA_WRITE
   } cdma_state_e;
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } cdma_bus_s;
   typedef struct packed {
      logic req;
      logic we;
      logic [31:0] addr;
      logic [31:0] wdata;
   } cdma_mem_s;
endpackage

//--- rtl/cdma_engine.sv
// Chunked DMA engine: transfer description registers, status and a byte-wide memory mover.
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "cdma_consts.svh"
module cdma_engine #(
   parameter int CNT_W = 12,
   parameter int LEN_W = 20,
   parameter logic [1:0] NOTIFY_LEVEL = 2'h1
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire cdma_pkg::cdma_bus_s bus_in,
   input wire logic [1:0] bus_level,
   output logic [31:0] bus_rdata,
   output cdma_pkg::cdma_mem_s mem_out,
   input wire logic mem_ack,
   input wire logic [7:0] mem_rdata,
   input wire logic mem_miss,
   input wire logic mem_violation,
   input wire logic mem_error,
   output logic completion_notify
);
   cdma_pkg::cdma_state_e state_ff, nxt_state;
   logic [31:0] dest_ptr_ff, dest_base_ff, src_ptr_ff, src_base_ff, strides_ff;
   logic [31:0] bytes_ff, chunk_size_ff;
   logic [LEN_W-1:0] left_ff;
   logic [7:0] data_ff;
   logic err_ff, run_ff, busy_ff, done_ff;
   logic [31:0] rdata_ff;
   cdma_pkg::cdma_mem_s mem_ff;
   logic notify_ff;

   // Access decode; the privilege gate keeps code below the notify level out.
   wire logic allowed = bus_level >= NOTIFY_LEVEL;
   wire logic wr = clk_en & bus_in.wr & allowed;
   wire logic rd = clk_en & bus_in.rd & allowed;
   wire logic wr_ctrl = wr && bus_in.addr == `CDMA_OFF_CONTROL;
   wire logic start = wr_ctrl && bus_in.wdata[`CDMA_BIT_REQUEST] && !busy_ff;
   wire logic suspend = wr_ctrl && bus_in.wdata[`CDMA_BIT_SUSPEND] && busy_ff && !start;
   wire logic wr_desc = wr && !busy_ff;
   wire logic [CNT_W-1:0] chunks_left = bytes_ff[31:32-CNT_W];
   wire logic [LEN_W-1:0] first_len = bytes_ff[LEN_W-1:0];
   wire logic [LEN_W-1:0] chunk_len = chunk_size_ff[LEN_W-1:0];
   wire logic fault = mem_ack && (mem_miss || mem_violation || mem_error);
   wire logic wr_beat = state_ff == cdma_pkg::CDMA_WRITE && mem_ack && !fault;
   wire logic chunk_end = wr_beat && left_ff == LEN_W'(1);
   wire logic last_chunk = chunks_left <= CNT_W'(1);
   wire logic finish = chunk_end && last_chunk;
   wire logic halt = busy_ff && (suspend || fault);
   wire logic [31:0] next_dest_base = dest_base_ff + {16'h0000, strides_ff[31:16]};
   wire logic [31:0] next_src_base = src_base_ff + {16'h0000, strides_ff[15:0]};
   wire logic [31:0] status_word = {25'h000_0000, err_ff, 1'b0, run_ff, 2'b00, busy_ff, done_ff};

   // Engine sequence: one read beat then one write beat per byte.
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         cdma_pkg::CDMA_IDLE: begin
            if (start && chunks_left != CNT_W'(0)) begin
               nxt_state = cdma_pkg::CDMA_READ;
            end
         end
         cdma_pkg::CDMA_READ: begin
            if (halt) begin
               nxt_state = cdma_pkg::CDMA_IDLE;
            end else if (mem_ack) begin
               nxt_state = cdma_pkg::CDMA_WRITE;
            end
         end
         cdma_pkg::CDMA_WRITE: begin
            if (halt || finish) begin
               nxt_state = cdma_pkg::CDMA_IDLE;
            end else if (mem_ack) begin
               nxt_state = cdma_pkg::CDMA_READ;
            end
         end
      endcase
   end

   // Combined memory request for the next cycle.
   wire logic go_read = nxt_state == cdma_pkg::CDMA_READ;
   wire logic go_write = nxt_state == cdma_pkg::CDMA_WRITE;
   // The source pointer moves only once its byte has been written.
   // A suspend between the read and the write then reads that byte again on resume, so no byte is lost.
   wire logic [31:0] nxt_src_ptr = wr_beat ? src_ptr_ff + 32'h0000_0001 : src_ptr_ff;
   // The first read of a new chunk must use the advanced base, not the old pointer.
   wire logic [31:0] nxt_rd_addr = (chunk_end && !last_chunk) ? next_src_base : nxt_src_ptr;

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff <= cdma_pkg::CDMA_IDLE;
      end else if (clk_en) begin
         state_ff <= nxt_state;
      end
   end

   // Description registers; software writes land only while the engine is idle.
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         dest_ptr_ff <= `CDMA_RST_WORD;
         dest_base_ff <= `CDMA_RST_WORD;
         src_ptr_ff <= `CDMA_RST_WORD;
         src_base_ff <= `CDMA_RST_WORD;
         strides_ff <= `CDMA_RST_WORD;
         bytes_ff <= `CDMA_RST_WORD;
         chunk_size_ff <= `CDMA_RST_WORD;
      end else if (clk_en) begin
         if (wr_desc && bus_in.addr == `CDMA_OFF_DEST_PTR) begin
            dest_ptr_ff <= bus_in.wdata;
         end
         if (wr_desc && bus_in.addr == `CDMA_OFF_DEST_BASE) begin
            dest_base_ff <= bus_in.wdata;
         end
         if (wr_desc && bus_in.addr == `CDMA_OFF_SRC_PTR) begin
            src_ptr_ff <= bus_in.wdata;
         end
         if (wr_desc && bus_in.addr == `CDMA_OFF_SRC_BASE) begin
            src_base_ff <= bus_in.wdata;
         end
         if (wr_desc && bus_in.addr == `CDMA_OFF_STRIDES) begin
            strides_ff <= bus_in.wdata;
         end
         if (wr_desc && bus_in.addr == `CDMA_OFF_BYTES) begin
            bytes_ff <= bus_in.wdata;
         end
         if (wr_desc && bus_in.addr == `CDMA_OFF_CHUNK_SIZE) begin
            chunk_size_ff <= bus_in.wdata;
         end
         if (busy_ff) begin
            src_ptr_ff <= nxt_src_ptr;
         end
         if (wr_beat) begin
            dest_ptr_ff <= dest_ptr_ff + 32'h0000_0001;
         end
         // Remaining byte length of the current chunk is kept in the low field so a suspend saves it.
         if (state_ff == cdma_pkg::CDMA_WRITE && mem_ack && !fault && !chunk_end) begin
            bytes_ff[LEN_W-1:0] <= left_ff - LEN_W'(1);
         end
         if (chunk_end && !last_chunk) begin
            dest_base_ff <= next_dest_base;
            src_base_ff <= next_src_base;
            dest_ptr_ff <= next_dest_base;
            src_ptr_ff <= next_src_base;
            bytes_ff <= {chunks_left - CNT_W'(1), chunk_len};
         end
      end
   end

   // Byte counter of the chunk in flight, loaded at start from the length field.
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         left_ff <= '0;
         data_ff <= 8'h00;
      end else if (clk_en) begin
         if (start) begin
            left_ff <= first_len;
         end else if (chunk_end) begin
            left_ff <= chunk_len;
         end else if (wr_beat) begin
            left_ff <= left_ff - LEN_W'(1);
         end
         if (state_ff == cdma_pkg::CDMA_READ && mem_ack) begin
            data_ff <= mem_rdata;
         end
      end
   end

   // Status flags; a start clears error and, unless no chunks are given, done; set wins over the software clear of done.
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         err_ff <= 1'b0;
         run_ff <= 1'b0;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
      end else if (clk_en) begin
         if (busy_ff && mem_ack && mem_error) begin
            err_ff <= 1'b1;
         end else if (start) begin
            err_ff <= 1'b0;
         end
         if (start) begin
            run_ff <= 1'b1;
         end else if (suspend) begin
            run_ff <= 1'b0;
         end
         if (start) begin
            busy_ff <= chunks_left != CNT_W'(0);
         end else if (halt || finish) begin
            busy_ff <= 1'b0;
         end
         if (finish || (start && chunks_left == CNT_W'(0))) begin
            done_ff <= 1'b1;
         end else if (start) begin
            done_ff <= 1'b0;
         end else if (wr && bus_in.addr == `CDMA_OFF_STATUS && bus_in.wdata[`CDMA_BIT_DONE] && !busy_ff) begin
            done_ff <= 1'b0;
         end
      end
   end

   // Read mux; unmapped offsets and refused accesses read zero.
   wire logic [31:0] rd_mux = !rd ? 32'h0000_0000
      : bus_in.addr == `CDMA_OFF_DEST_PTR ? dest_ptr_ff
      : bus_in.addr == `CDMA_OFF_DEST_BASE ? dest_base_ff
      : bus_in.addr == `CDMA_OFF_SRC_PTR ? src_ptr_ff
      : bus_in.addr == `CDMA_OFF_SRC_BASE ? src_base_ff
      : bus_in.addr == `CDMA_OFF_STRIDES ? strides_ff
      : bus_in.addr == `CDMA_OFF_STATUS ? status_word
      : bus_in.addr == `CDMA_OFF_BYTES ? bytes_ff
      : bus_in.addr == `CDMA_OFF_CHUNK_SIZE ? chunk_size_ff
      : 32'h0000_0000;

   // Registered outputs: read data, memory request and interrupt.
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_ff <= 32'h0000_0000;
         mem_ff <= '0;
         notify_ff <= 1'b0;
      end else if (clk_en) begin
         rdata_ff <= rd_mux;
         mem_ff.req <= go_read || go_write;
         mem_ff.we <= go_write;
         mem_ff.addr <= go_write ? dest_ptr_ff : nxt_rd_addr;
         mem_ff.wdata <= {24'h00_0000, (state_ff == cdma_pkg::CDMA_READ && mem_ack) ? mem_rdata : data_ff};
         notify_ff <= nxt_done();
      end
   end

   // Next value of the done flag, so the interrupt tracks it with no extra lag.
   function automatic logic nxt_done();
      logic v;
      v = done_ff;
      if (finish || (start && chunks_left == CNT_W'(0))) begin
         v = 1'b1;
      end else if (start) begin
         v = 1'b0;
      end else if (wr && bus_in.addr == `CDMA_OFF_STATUS && bus_in.wdata[`CDMA_BIT_DONE] && !busy_ff) begin
         v = 1'b0;
      end
      return v;
   endfunction

   assign bus_rdata = rdata_ff;
   assign mem_out = mem_ff;
   assign completion_notify = notify_ff;
endmodule // cdma_engine

//--- testbench/cdma_mem_model.sv
// Memory partner model that answers the engine's byte requests.
`timescale 1ns/1ps
module cdma_mem_model (
   input wire logic ref_clk,
   input wire cdma_pkg::cdma_mem_s mem_out,
   input wire logic [1:0] wait_cyc,
   input wire logic fault,
   output logic mem_ack,
   output logic [7:0] mem_rdata,
   output logic mem_error
);
   logic ack_ff = 1'b0;
   logic [1:0] cnt_ff = 2'h0;
   logic [7:0] rd_ff = 8'h00;
   logic [31:0] log_q[$];
   // The answer is gated by req so a dropped request is never acknowledged.
   assign mem_ack = ack_ff && mem_out.req;
   assign mem_error = mem_ack && fault;
   assign mem_rdata = rd_ff;
   // Answer wait_cyc+1 cycles after the request appears; an idle data line toggles instead of holding.
   always @(posedge ref_clk) begin
      rd_ff <= ~rd_ff;
      if (mem_ack) begin
         log_q.push_back(mem_out.addr);
         ack_ff <= 1'b0;
         cnt_ff <= 2'h0;
      end else if (!mem_out.req) begin
         // A withdrawn request leaves no armed answer behind for the next one.
         ack_ff <= 1'b0;
         cnt_ff <= 2'h0;
      end else if (cnt_ff == wait_cyc) begin
         ack_ff <= 1'b1;
         rd_ff <= mem_out.addr[7:0] ^ 8'h5A;
      end else if (mem_out.req) begin
         cnt_ff <= cnt_ff + 2'h1;
      end
   end
endmodule // cdma_mem_model

//--- testbench/cdma_checker.sv
// Port assertions for the chunked DMA engine.
`timescale 1ns/1ps
module cdma_checker #(
   parameter logic [1:0] NOTIFY_LEVEL = 2'h1
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire cdma_pkg::cdma_bus_s bus_in,
   input wire logic [1:0] bus_level,
   input wire logic [31:0] bus_rdata,
   input wire cdma_pkg::cdma_mem_s mem_out,
   input wire logic mem_ack,
   input wire logic [7:0] mem_rdata,
   input wire logic mem_miss,
   input wire logic mem_violation,
   input wire logic mem_error,
   input wire logic completion_notify
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // Decoded accesses; refused ones are excluded so they arm no property but p_low.
   wire ok_acc = clk_en && bus_level >= NOTIFY_LEVEL;
   wire ctl_wr = ok_acc && bus_in.wr && bus_in.addr == 8'h18;
   wire sts_w1c = ok_acc && bus_in.wr && bus_in.addr == 8'h14 && bus_in.wdata[0];
   wire fault = mem_miss || mem_violation || mem_error;
   sequence s_rd_beat; mem_out.req && !mem_out.we && mem_ack && !fault && clk_en && !ctl_wr; endsequence
   sequence s_wr_issue; mem_out.req && mem_out.we; endsequence
   property p_hold; mem_out.req && !mem_ack && clk_en && !ctl_wr |=> mem_out.req && $stable(mem_out.addr); endproperty
   property p_copy; s_rd_beat |=> s_wr_issue ##0 mem_out.wdata[7:0] == $past(mem_rdata); endproperty
   property p_keep; completion_notify && !(ok_acc && bus_in.wr) |=> completion_notify; endproperty
   property p_w1c; completion_notify && sts_w1c |=> !completion_notify; endproperty
   property p_fault; mem_out.req && mem_ack && fault |=> !mem_out.req && !completion_notify; endproperty
   property p_idle; completion_notify |-> !mem_out.req; endproperty
   property p_susp; mem_out.req && ctl_wr && bus_in.wdata[1:0] == 2'b10 |-> ##[1:2] !mem_out.req; endproperty
   property p_low; clk_en && bus_in.rd && bus_level < NOTIFY_LEVEL |=> bus_rdata == 32'h0000_0000; endproperty
   a_hold: assert property (p_hold) else $error("request dropped or moved unanswered");
   a_copy: assert property (p_copy) else $error("written byte differs from read byte");
   a_keep: assert property (p_keep) else $error("notify fell without a write");
   a_w1c: assert property (p_w1c) else $error("done not cleared by write one");
   a_fault: assert property (p_fault) else $error("engine went on after a fault");
   a_idle: assert property (p_idle) else $error("request while done");
   a_susp: assert property (p_susp) else $error("suspend did not stop requests");
   a_low: assert property (p_low) else $error("low level read returned data");
endmodule // cdma_checker
bind cdma_engine cdma_checker #(.NOTIFY_LEVEL(NOTIFY_LEVEL)) cdma_checker_inst (.ref_clk(ref_clk),
   .sys_rst(sys_rst), .clk_en(clk_en), .bus_in(bus_in), .bus_level(bus_level), .bus_rdata(bus_rdata),
   .mem_out(mem_out), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_miss(mem_miss),
   .mem_violation(mem_violation), .mem_error(mem_error), .completion_notify(completion_notify));

//--- testbench/cdma_engine_tb.sv
// Self-checking bench for the chunked DMA engine.
`timescale 1ns/1ps
module cdma_engine_tb;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} cdma_row_s;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   cdma_pkg::cdma_bus_s bus_in = '0;
   logic [1:0] bus_level = 2'h1;
   logic [1:0] wait_cyc = 2'h0;
   logic fault = 1'b0;
   logic [31:0] bus_rdata;
   cdma_pkg::cdma_mem_s mem_out;
   logic mem_ack, mem_error, completion_notify;
   logic [7:0] mem_rdata;
   int fail_count = 0, comparisons = 0, cyc = 0;
   cdma_row_s rows[9] = '{'{8'h00, 32'h1234_5678, 32'h1234_5678}, '{8'h04, 32'hFFFF_FFFF, 32'hFFFF_FFFF},
      '{8'h08, 32'h8000_0001, 32'h8000_0001}, '{8'h0C, 32'h0000_0004, 32'h0000_0004},
      '{8'h10, 32'hABCD_0123, 32'hABCD_0123}, '{8'h1C, 32'h0020_0002, 32'h0020_0002},
      '{8'h20, 32'h000F_FFFF, 32'h000F_FFFF}, '{8'h18, 32'h0000_0000, 32'h0000_0000},
      '{8'h40, 32'h5555_AAAA, 32'h0000_0000}};
   logic [31:0] exp_a[10] = '{32'h0000_0100, 32'h0000_0200, 32'h0000_0101, 32'h0000_0201, 32'h0000_0120,
      32'h0000_0210, 32'h0000_0121, 32'h0000_0211, 32'h0000_0122, 32'h0000_0212};
   // Device and partner; clk_en, miss and violation inputs are the only ties.
   cdma_engine cdma_engine_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(1'b1), .bus_in(bus_in),
      .bus_level(bus_level), .bus_rdata(bus_rdata), .mem_out(mem_out), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
      .mem_miss(1'b0), .mem_violation(1'b0), .mem_error(mem_error), .completion_notify(completion_notify));
   cdma_mem_model cdma_mem_model_inst (.ref_clk(ref_clk), .mem_out(mem_out), .wait_cyc(wait_cyc),
      .fault(fault), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_error(mem_error));
   // Clock and a hang guard well above the few hundred cycles the run needs.
   always #4 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         conclude();
      end
   end
   task automatic conclude();
      $display("mismatches %0d comparisons %0d", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      bus_in.wr <= 1'b0;
      // Let one edge pass so the next call never drives the strobe twice in one step.
      @(posedge ref_clk);
   endtask
   // Read data stand only in the cycle after the strobe, so they are taken at its closing edge.
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus_in <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      bus_in.rd <= 1'b0;
      @(posedge ref_clk);
      chk(bus_rdata, e);
   endtask
   task automatic setup(input logic [31:0] sb, db, st, by);
      wr(8'h08, sb);
      wr(8'h0C, sb);
      wr(8'h00, db);
      wr(8'h04, db);
      wr(8'h10, st);
      wr(8'h1C, by);
      wr(8'h20, 32'h0000_0003);
      cdma_mem_model_inst.log_q.delete();
      wr(8'h18, 32'h0000_0001);
   endtask
   task automatic wait_done();
      while (completion_notify !== 1'b1) @(posedge ref_clk);
   endtask
   // Main sequence: reset values, table rows, then the awkward cases.
   initial begin
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      for (int i = 0; i < 6; i++) rd(8'(4 * i), 32'h0);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].e);
      end
      setup(32'h0000_0100, 32'h0000_0200, 32'h0010_0020, 32'h0020_0002);
      wait_done();
      foreach (exp_a[i]) chk(cdma_mem_model_inst.log_q[i], exp_a[i]);
      rd(8'h14, 32'h0000_0011);
      wr(8'h14, 32'h0000_0001);
      rd(8'h14, 32'h0000_0010);
      chk(32'(completion_notify), 32'h0);
      wait_cyc <= 2'h3;
      setup(32'h0000_0300, 32'h0000_0400, 32'h0, 32'h0010_0008);
      repeat (6) @(posedge ref_clk);
      wr(8'h18, 32'h0000_0001);
      repeat (10) @(posedge ref_clk);
      wr(8'h18, 32'h0000_0002);
      rd(8'h14, 32'h0000_0000);
      rd(8'h00, 32'h0000_0400 + 32'(cdma_mem_model_inst.log_q.size() / 2));
      wr(8'h18, 32'h0000_0001);
      wait_done();
      chk(32'(cdma_mem_model_inst.log_q.size() / 2), 32'h8);
      chk(cdma_mem_model_inst.log_q[$], 32'h0000_0407);
      wait_cyc <= 2'h0;
      fault <= 1'b1;
      setup(32'h0000_0500, 32'h0000_0600, 32'h0, 32'h0010_0002);
      repeat (8) @(posedge ref_clk);
      fault <= 1'b0;
      rd(8'h14, 32'h0000_0050);
      // Running is still set after the fault, but busy is clear, so software may restart the engine.
      wr(8'h18, 32'h0000_0001);
      wait_done();
      rd(8'h14, 32'h0000_0011);
      wr(8'h0C, 32'h0000_0005);
      bus_level <= 2'h0;
      wr(8'h0C, 32'hDEAD_BEEF);
      rd(8'h14, 32'h0000_0000);
      bus_level <= 2'h1;
      rd(8'h0C, 32'h0000_0005);
      conclude();
   end
endmodule // cdma_engine_tb
